/* nvm_pkg.sv */
// Purpose: shared constants and carriers for the memory access and boot config block
// Assumes: 20 MHz pclk, 32-bit APB register words
// Notes: register indices sit at byte address index*4
package nvm_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int EE_WRITE_TIME_NS = 20000;
	localparam int EE_WRITE_CYCLES = (EE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [2:0] REG_PORT_DRIVE_CFG_LOW = 3'h0;
	localparam logic [2:0] REG_PORT_DRIVE_CFG_HIGH = 3'h1;
	localparam logic [2:0] REG_RESET_PIN_CFG = 3'h2;
	localparam logic [2:0] REG_BOOT_DEBUG_ECC_CFG = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [2:0] REG_PROT_CMD = 3'h5;
	localparam logic [2:0] REG_EE_CMD = 3'h6;
	localparam logic [2:0] REG_EE_DATA = 3'h7;
	// ------------------------------------------------------------
	// config latch reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [7:0] CFG2_RST = 8'h00;
	localparam logic [7:0] CFG3_RST = 8'h02;
	localparam int XRES_BIT = 7;
	localparam int SPEED_BIT = 0;
	localparam int DPS_LSB = 1;
	localparam int ECC_SPACE_ENABLE_BIT = 3;
	localparam int PHS_LSB = 4;
	localparam logic [1:0] DBG_DISABLED = 2'h3;
	// status bits
	localparam int ST_EE_BUSY = 0;
	localparam int ST_PROT_REFUSED = 1;
	localparam int ST_SECURED = 2;
	localparam int ST_ECC_SINGLE = 3;
	localparam int ST_ECC_DOUBLE = 4;
	localparam int ST_EE_REFUSED = 5;
	// ------------------------------------------------------------
	// memory geometry
	// ------------------------------------------------------------
	localparam int SRAM_BYTES = 8192;
	localparam int SRAM_BLK_BIT = 12;
	localparam int FLASH_BLOCKS = 256;
	localparam int EE_ROWS = 128;
	localparam int EE_ROW_BYTES = 16;
	localparam int EE_BYTES = EE_ROWS * EE_ROW_BYTES;
	// protection levels, lowest to highest
	typedef enum logic [1:0] {PROT_NONE, PROT_FACTORY, PROT_FIELD, PROT_FULL} prot_level_t;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [17:0] port_reset_drive_mode;
		logic ext_reset_pin_enable;
		logic boot_clock_speed;
		logic [1:0] debug_port_select;
		logic ecc_space_enable;
		logic [3:0] digital_clock_phase_delay;
	} boot_cfg_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [12:0] addr;
		logic [7:0] wdata;
	} sram_req_t;
endpackage

/* nvm_access_and_boot_config.sv */
// Purpose: SRAM arbitration, flash row fetch with ECC, row protection, EEPROM access,
//   boot configuration latches, APB register access
// Assumes: flash macro answers a row read with flash_rvalid; programming interface
//   drives prog_busy, full_erase_* and secure_engage
// Notes: config latches are emulated by flops loaded with factory values at reset
//
// How it works
// - cpu and dma share SRAM across 4KB blocks
// - ecc fixes single, flags double bit errors
// - flash rows fill an 8-byte fetch buffer
// - fetch from ecc section is refused
// - flash programming stalls instruction fetch
// - 256 blocks of 256 plus 32 bytes
// - protection level changes only at presetn or during full erase
// - factory level blocks external reads only
// - field and full block all external access
// - full level blocks internal writes too
// - security lock disables debug and test ports
// - eeprom reads direct, writes by command
// - eeprom writes never stall flash fetch
// - eeprom is 128 rows of 16 bytes
// - eeprom has no ecc, no fetch
// - four config latch bytes configure at reset
// - two-bit drive mode per port
// - reset pin enable selects gpio or reset
// - boot clock speed selects 12 or 48 MHz
// - debug port select field chooses debug pins
// - ecc space enable turns checking on
// - upper nibble of byte 3 sets phase delay
`timescale 1ns/100ps
module nvm_access_and_boot_config import nvm_pkg::*; #(
	parameter logic XRES_DEFAULT = 1'b0
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sram ports
	input wire sram_req_t cpu_sram,
	output logic cpu_sram_gnt,
	output logic [7:0] cpu_sram_rdata,
	input wire sram_req_t dma_sram,
	output logic dma_sram_gnt,
	output logic [7:0] dma_sram_rdata,
	// instruction fetch
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_ecc_section,
	output logic fetch_ack,
	output logic fetch_err,
	output logic [7:0] fetch_data,
	output logic ecc_single_event,
	output logic ecc_double_event,
	// flash macro
	output logic flash_rd,
	output logic [12:0] flash_row,
	input wire logic [71:0] flash_rdata,
	input wire logic flash_rvalid,
	// programming interface and protection check
	input wire logic prog_busy,
	input wire logic full_erase_start,
	input wire logic full_erase_busy,
	input wire logic secure_engage,
	input wire logic acc_ext,
	input wire logic acc_write,
	input wire logic [7:0] acc_block,
	output logic acc_allow,
	// eeprom read port
	input wire logic ee_rd,
	input wire logic [10:0] ee_addr,
	output logic ee_rvalid,
	output logic [7:0] ee_rdata,
	// boot configuration
	output boot_cfg_t boot_cfg,
	output logic test_ports_disabled
);
	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic [7:0] cfg [4];
	logic [5:0] status;
	logic secured;
	logic ee_busy;
	logic [6:0] ee_row;
	logic [3:0] ee_ptr;
	logic [$clog2(EE_WRITE_CYCLES+1)-1:0] ee_cnt;
	logic [1:0] prot [FLASH_BLOCKS];
	logic mapped;
	logic wr_en;
	logic [2:0] idx;
	assign idx = paddr[4:2];
	assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
	assign wr_en = psel && penable && pwrite && mapped;
	// zero wait states keep the master simple
	assign pready = 1'b1;

	// read data and error latched in setup, valid through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !mapped;
			prdata <= 32'h00000000;
			if (mapped && !pwrite) begin
				case (idx)
					REG_STATUS: prdata <= {26'h0, status};
					REG_EE_CMD: prdata <= {25'h0, ee_row};
					REG_EE_DATA: prdata <= {28'h0, ee_ptr};
					REG_PROT_CMD: prdata <= 32'h00000000;
					default: prdata <= {24'h0, cfg[idx[1:0]]};
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// config latch array and boot settings
	// ------------------------------------------------------------
	logic cfg_loaded;

	// latch bytes take new values, but reset reloads the factory values, so written bytes never reach boot_cfg
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg[0] <= CFG0_RST;
			cfg[1] <= CFG1_RST;
			cfg[2] <= CFG2_RST | ({7'h00, XRES_DEFAULT} << XRES_BIT);
			cfg[3] <= CFG3_RST;
		end else if (wr_en && idx[2] == 1'b0) begin
			cfg[idx[1:0]] <= pwdata[7:0];
		end
	end

	// one capture right after release; later writes do not disturb the live settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_loaded <= 1'b0;
			boot_cfg <= '0;
		end else if (!cfg_loaded) begin
			cfg_loaded <= 1'b1;
			boot_cfg.port_reset_drive_mode <= {cfg[2][1:0], cfg[1], cfg[0]};
			boot_cfg.ext_reset_pin_enable <= cfg[2][XRES_BIT];
			boot_cfg.boot_clock_speed <= cfg[3][SPEED_BIT];
			boot_cfg.debug_port_select <= cfg[3][DPS_LSB +: 2];
			boot_cfg.ecc_space_enable <= cfg[3][ECC_SPACE_ENABLE_BIT];
			boot_cfg.digital_clock_phase_delay <= cfg[3][PHS_LSB +: 4];
		end else if (secured) begin
			boot_cfg.debug_port_select <= DBG_DISABLED;
		end
	end

	// security lock: only presetn clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secured <= 1'b0;
		end else if (secure_engage) begin
			secured <= 1'b1;
		end
	end
	assign test_ports_disabled = secured;

	// ------------------------------------------------------------
	// sram arbitration
	// ------------------------------------------------------------
	logic [7:0] sram_mem [SRAM_BYTES];
	logic same_blk;
	assign same_blk = cpu_sram.addr[SRAM_BLK_BIT] == dma_sram.addr[SRAM_BLK_BIT];
	// cpu has priority; dma only waits on a collision inside one 4KB block
	assign cpu_sram_gnt = cpu_sram.req;
	assign dma_sram_gnt = dma_sram.req && !(cpu_sram.req && same_blk);

	// two independent banks, one access each per cycle
	always_ff @(posedge pclk) begin
		if (cpu_sram_gnt && cpu_sram.we) sram_mem[cpu_sram.addr] <= cpu_sram.wdata;
		if (dma_sram_gnt && dma_sram.we) sram_mem[dma_sram.addr] <= dma_sram.wdata;
		cpu_sram_rdata <= sram_mem[cpu_sram.addr];
		dma_sram_rdata <= sram_mem[dma_sram.addr];
	end

	// ------------------------------------------------------------
	// flash fetch with ecc
	// ------------------------------------------------------------
	// returns {double, single, corrected data}
	function automatic logic [65:0] ecc_fix(input logic [71:0] row);
		logic [6:0] syn;
		logic [6:0] pos;
		logic [63:0] d;
		logic par;
		syn = row[70:64];
		par = ^row;
		d = row[63:0];
		pos = 7'd3;
		for (int i = 0; i < 64; i++) begin
			if (d[i]) syn = syn ^ pos;
			pos = pos + 7'd1;
			if ((pos & (pos - 7'd1)) == 7'd0) pos = pos + 7'd1;
		end
		pos = 7'd3;
		for (int i = 0; i < 64; i++) begin
			if (par && syn == pos) d[i] = !d[i];
			pos = pos + 7'd1;
			if ((pos & (pos - 7'd1)) == 7'd0) pos = pos + 7'd1;
		end
		return {!par && syn != 7'd0, par, d};
	endfunction

	typedef enum {F_IDLE, F_READ} fetch_state_t;
	fetch_state_t fstate;
	logic [63:0] ibuf;
	logic [12:0] ibuf_tag;
	logic ibuf_valid;
	logic [65:0] fixed;
	logic hit;
	assign fixed = ecc_fix(flash_rdata);
	assign hit = ibuf_valid && ibuf_tag == fetch_addr[15:3];
	assign flash_rd = fstate == F_READ;

	// fetch engine; eeprom activity is not an input here on purpose
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fstate <= F_IDLE;
			ibuf <= 64'h0;
			ibuf_tag <= 13'h0;
			ibuf_valid <= 1'b0;
			flash_row <= 13'h0;
			fetch_ack <= 1'b0;
			fetch_err <= 1'b0;
			fetch_data <= 8'h00;
			ecc_single_event <= 1'b0;
			ecc_double_event <= 1'b0;
		end else begin
			fetch_ack <= 1'b0;
			fetch_err <= 1'b0;
			ecc_single_event <= 1'b0;
			ecc_double_event <= 1'b0;
			case (fstate)
				F_IDLE: begin
					if (prog_busy) begin
						ibuf_valid <= 1'b0;
					end else if (fetch_req && fetch_ecc_section) begin
						fetch_ack <= 1'b1;
						fetch_err <= 1'b1;
					end else if (fetch_req && hit) begin
						fetch_ack <= 1'b1;
						fetch_data <= ibuf[fetch_addr[2:0]*8 +: 8];
					end else if (fetch_req) begin
						flash_row <= fetch_addr[15:3];
						fstate <= F_READ;
					end
				end
				F_READ: begin
					if (flash_rvalid) begin
						ibuf_tag <= flash_row;
						ibuf_valid <= !prog_busy;
						fstate <= F_IDLE;
						if (boot_cfg.ecc_space_enable) begin
							ibuf <= fixed[63:0];
							ecc_single_event <= fixed[64];
							ecc_double_event <= fixed[65];
						end else begin
							ibuf <= flash_rdata[63:0];
						end
					end
				end
				default: fstate <= F_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// row protection
	// ------------------------------------------------------------
	prot_level_t lvl;
	logic prot_wr;
	assign lvl = prot_level_t'(prot[acc_block]);
	assign prot_wr = wr_en && idx == REG_PROT_CMD;

	// level table: cleared by a full erase, written only while it runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < FLASH_BLOCKS; i++) prot[i] <= 2'h0;
		end else if (full_erase_start) begin
			for (int i = 0; i < FLASH_BLOCKS; i++) prot[i] <= 2'h0;
		end else if (prot_wr && full_erase_busy) begin
			prot[pwdata[7:0]] <= pwdata[9:8];
		end
	end

	// access check for the programming and debug path
	always_comb begin
		case (lvl)
			PROT_NONE: acc_allow = 1'b1;
			PROT_FACTORY: acc_allow = !(acc_ext && !acc_write);
			PROT_FIELD: acc_allow = !acc_ext;
			PROT_FULL: acc_allow = !acc_ext && !acc_write;
			default: acc_allow = 1'b0;
		endcase
		if (secured && acc_ext) acc_allow = 1'b0;
	end

	// ------------------------------------------------------------
	// eeprom
	// ------------------------------------------------------------
	logic [7:0] ee_mem [EE_BYTES];
	logic [7:0] ee_rowbuf [EE_ROW_BYTES];
	logic ee_go;
	logic ee_done;
	assign ee_go = wr_en && idx == REG_EE_CMD && !ee_busy;
	assign ee_done = ee_busy && ee_cnt == 1;

	// direct byte reads, no correction; nothing here feeds the fetch buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ee_rvalid <= 1'b0;
			ee_rdata <= 8'h00;
		end else begin
			ee_rvalid <= ee_rd;
			if (ee_rd) ee_rdata <= ee_mem[ee_addr];
		end
	end

	// write command sequencer; a command during a write is refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ee_busy <= 1'b0;
			ee_row <= 7'h00;
			ee_cnt <= '0;
			ee_ptr <= 4'h0;
		end else begin
			if (ee_go) begin
				ee_busy <= 1'b1;
				ee_row <= pwdata[6:0];
				ee_cnt <= ($clog2(EE_WRITE_CYCLES+1))'(EE_WRITE_CYCLES);
				ee_ptr <= 4'h0;
			end else if (ee_busy) begin
				ee_cnt <= ee_cnt - 1'b1;
				if (ee_done) ee_busy <= 1'b0;
			end else if (wr_en && idx == REG_EE_DATA) begin
				ee_ptr <= ee_ptr + 4'h1;
			end
		end
	end

	// row staging buffer, filled one byte per data write
	always_ff @(posedge pclk) begin
		if (wr_en && idx == REG_EE_DATA && !ee_busy) ee_rowbuf[ee_ptr] <= pwdata[7:0];
	end

	// whole row replaced at once: erase and write never touch part of a row
	always_ff @(posedge pclk) begin
		if (ee_done) begin
			for (int i = 0; i < EE_ROW_BYTES; i++) begin
				ee_mem[{ee_row, 4'(i)}] <= ee_rowbuf[i];
			end
		end
	end

	// ------------------------------------------------------------
	// status
	// ------------------------------------------------------------
	logic [5:0] st_set;
	logic [5:0] st_clr;
	always_comb begin
		st_set = '0;
		st_set[ST_PROT_REFUSED] = prot_wr && !full_erase_busy;
		st_set[ST_ECC_SINGLE] = ecc_single_event;
		st_set[ST_ECC_DOUBLE] = ecc_double_event;
		st_set[ST_EE_REFUSED] = wr_en && idx == REG_EE_CMD && ee_busy;
		st_clr = (wr_en && idx == REG_STATUS) ? pwdata[5:0] : 6'h00;
	end

	// event flags sticky, write one to clear; a set in the same cycle wins; ee busy and secured follow live state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 6'h00;
		end else begin
			status <= (status & ~st_clr) | st_set;
			status[ST_EE_BUSY] <= ee_busy;
			status[ST_SECURED] <= secured;
		end
	end
endmodule

/* nvm_access_and_boot_config_properties.sv */
// Purpose: port checks for the nvm access block
// Assumes: one pclk domain, async active-low presetn
// Notes: bound to the top module below
`timescale 1ns/100ps
module nvm_access_and_boot_config_properties import nvm_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// watched ports
	input wire sram_req_t cpu_sram,
	input wire sram_req_t dma_sram,
	input wire logic cpu_sram_gnt,
	input wire logic dma_sram_gnt,
	input wire logic prog_busy,
	input wire logic fetch_ack,
	input wire logic fetch_err,
	input wire logic ecc_single_event,
	input wire logic ecc_double_event,
	input wire logic acc_ext,
	input wire logic acc_allow,
	input wire logic ee_rd,
	input wire logic ee_rvalid,
	input wire boot_cfg_t boot_cfg,
	input wire logic test_ports_disabled
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// eeprom read request and its answer
	sequence ee_ask;
		ee_rd;
	endsequence
	sequence ee_back;
		ee_rvalid;
	endsequence
	sram_split_a: assert property (cpu_sram.req && dma_sram.req && cpu_sram.addr[12] !=
		dma_sram.addr[12] |-> cpu_sram_gnt && dma_sram_gnt) else $error("split grant");
	sram_serial_a: assert property (cpu_sram.req && dma_sram.req && cpu_sram.addr[12] ==
		dma_sram.addr[12] |-> cpu_sram_gnt && !dma_sram_gnt) else $error("same block");
	fetch_stall_a: assert property ($past(prog_busy) && prog_busy |-> !fetch_ack)
		else $error("fetch during programming");
	fetch_refuse_a: assert property (fetch_err |-> fetch_ack) else $error("err alone");
	ecc_quiet_a: assert property (!boot_cfg.ecc_space_enable |->
		!ecc_single_event && !ecc_double_event) else $error("ecc event while off");
	secure_ext_a: assert property (test_ports_disabled && acc_ext |-> !acc_allow)
		else $error("ext access when secured");
	secure_dbg_a: assert property (test_ports_disabled [*2] |->
		boot_cfg.debug_port_select == DBG_DISABLED) else $error("debug open");
	// the capture edge itself is the one change allowed after release
	cfg_hold_a: assert property ($past(presetn, 2) |->
		$stable({boot_cfg.port_reset_drive_mode,
		boot_cfg.ext_reset_pin_enable, boot_cfg.boot_clock_speed, boot_cfg.ecc_space_enable,
		boot_cfg.digital_clock_phase_delay})) else $error("config moved");
	ee_read_a: assert property (ee_ask |=> ee_back) else $error("ee read late");
endmodule
bind nvm_access_and_boot_config nvm_access_and_boot_config_properties u_props (.pclk(pclk),
	.presetn(presetn), .cpu_sram(cpu_sram), .dma_sram(dma_sram), .cpu_sram_gnt(cpu_sram_gnt),
	.dma_sram_gnt(dma_sram_gnt), .prog_busy(prog_busy), .fetch_ack(fetch_ack),
	.fetch_err(fetch_err), .ecc_single_event(ecc_single_event),
	.ecc_double_event(ecc_double_event), .acc_ext(acc_ext), .acc_allow(acc_allow),
	.ee_rd(ee_rd), .ee_rvalid(ee_rvalid), .boot_cfg(boot_cfg),
	.test_ports_disabled(test_ports_disabled));

/* nvm_flash_model.sv */
// Purpose: flash macro model answering row reads
// Assumes: lat sets idle cycles before the answer
// Notes: a released data bus shows the inverse of its last value
`timescale 1ns/100ps
module nvm_flash_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// macro side
	input wire logic flash_rd,
	input wire logic [12:0] flash_row,
	input wire logic [3:0] lat,
	output logic [71:0] flash_rdata,
	output logic flash_rvalid
);
	logic [3:0] cnt;
	// byte i of a row is its low row byte plus i, check byte is hamming plus parity
	function automatic logic [71:0] row_word(input logic [12:0] r);
		logic [71:1] c;
		logic [71:0] w;
		int j;
		c = '0;
		j = 0;
		for (int i = 0; i < 8; i++) w[8*i+:8] = r[7:0] + 8'(i);
		for (int p = 3; p < 72; p++) if ((p & (p - 1)) != 0) begin
			c[p] = w[j];
			j++;
		end
		for (int k = 0; k < 7; k++) begin
			w[64+k] = 1'b0;
			for (int p = 1; p < 72; p++) if (p[k]) w[64+k] ^= c[p];
		end
		w[71] = ^w[70:0];
		return w;
	endfunction
	// one 9-byte row per read, data only while rvalid stands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			flash_rvalid <= 1'b0;
			flash_rdata <= '0;
		end else begin
			flash_rvalid <= 1'b0;
			if (flash_rd && !flash_rvalid) begin
				cnt <= cnt + 4'h1;
				if (cnt >= lat) begin
					flash_rvalid <= 1'b1;
					flash_rdata <= row_word(flash_row);
					cnt <= 4'h0;
				end
			end else begin
				cnt <= 4'h0;
				flash_rdata <= ~flash_rdata;
			end
		end
	end
endmodule

/* tb_nvm_access_and_boot_config.sv */
// Purpose: self-checking bench for the nvm access block
// Assumes: apb zero-wait slave, flash model on the macro side
// Notes: reset reloads factory latch values, so latch writes never reach boot_cfg and defaults are seen live
`timescale 1ns/100ps
module tb_nvm_access_and_boot_config import nvm_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, fe, cpu_sram_gnt, dma_sram_gnt, fetch_ack, fetch_err;
	logic ecc_single_event, ecc_double_event, flash_rd, flash_rvalid, acc_allow, ee_rvalid;
	logic test_ports_disabled, fetch_req = 0, fetch_ecc_section = 0, prog_busy = 0;
	logic full_erase_start = 0, full_erase_busy = 0, secure_engage = 0;
	logic acc_ext = 0, acc_write = 0, ee_rd = 0;
	sram_req_t cpu_sram = '0, dma_sram = '0;
	logic [15:0] fetch_addr = '0;
	logic [7:0] acc_block = '0, cpu_sram_rdata, dma_sram_rdata, fetch_data, ee_rdata;
	logic [10:0] ee_addr = '0;
	logic [3:0] lat = '0;
	logic [12:0] flash_row;
	logic [71:0] flash_rdata;
	boot_cfg_t boot_cfg;
	int n_errors = 0, checks_done = 0;
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	nvm_access_and_boot_config #(.XRES_DEFAULT(1'b0)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_sram, .cpu_sram_gnt,
		.cpu_sram_rdata, .dma_sram, .dma_sram_gnt, .dma_sram_rdata, .fetch_req, .fetch_addr,
		.fetch_ecc_section, .fetch_ack, .fetch_err, .fetch_data, .ecc_single_event,
		.ecc_double_event, .flash_rd, .flash_row, .flash_rdata, .flash_rvalid, .prog_busy,
		.full_erase_start, .full_erase_busy, .secure_engage, .acc_ext, .acc_write, .acc_block,
		.acc_allow, .ee_rd, .ee_addr, .ee_rvalid, .ee_rdata, .boot_cfg, .test_ports_disabled);
	nvm_flash_model u_flash (.pclk, .presetn, .flash_rd, .flash_row, .lat, .flash_rdata,
		.flash_rvalid);
	// 20 MHz clock
	always #25 pclk = ~pclk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task stop_test;
		$display("n_errors %0d checks_done %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cmp_w(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t value %h expected %h", $time, g, e);
		end
	endtask
	task cmp_b(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t flag %b expected %b", $time, g, e);
		end
	endtask
	// setup cycle, then access until pready; the idle edge first avoids double drives
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// req held until ack; the retake that may follow is let pass
	task fetch(input logic [15:0] a, input logic sect);
		int n;
		n = 0;
		@(posedge pclk);
		fetch_addr <= a;
		fetch_ecc_section <= sect;
		fetch_req <= 1'b1;
		do begin
			@(negedge pclk);
			n++;
		end while (fetch_ack !== 1'b1 && n < 60);
		cmp_b(fetch_ack, 1'b1);
		fe = fetch_err;
		@(posedge pclk);
		fetch_req <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic [31:0] byte_of(input logic [15:0] a);
		return {24'h0, a[10:3] + {5'h0, a[2:0]}};
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		apb(1'b0, 12'h00c, 32'h0);
		cmp_w(rd, 32'h0000_0002);
		cmp_w({5'h0, boot_cfg}, {5'h0, 18'h0, 1'b0, 1'b0, 2'h1, 1'b0, 4'h0});
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'(4 * i), 32'h0000_00c3 ^ i);
			apb(1'b0, 12'(4 * i), 32'h0);
			cmp_w(rd, 32'h0000_00c3 ^ i);
		end
		cmp_w({5'h0, boot_cfg}, {5'h0, 18'h0, 1'b0, 1'b0, 2'h1, 1'b0, 4'h0});
		apb(1'b0, 12'h020, 32'h0);
		cmp_b(er, 1'b1);
	endtask
	task t_fetch;
		lat <= 4'h5;
		fetch(16'h0a5b, 1'b0);
		cmp_w({24'h0, fetch_data}, byte_of(16'h0a5b));
		fetch(16'h0a58, 1'b0);
		cmp_w({24'h0, fetch_data}, byte_of(16'h0a58));
		lat <= 4'h0;
		fetch(16'h0013, 1'b0);
		cmp_w({24'h0, fetch_data}, byte_of(16'h0013));
		fetch(16'h0013, 1'b1);
		cmp_b(fe, 1'b1);
		// a hit address held through programming must not be served
		@(posedge pclk);
		prog_busy <= 1'b1;
		fetch_addr <= 16'h0013;
		fetch_ecc_section <= 1'b0;
		fetch_req <= 1'b1;
		repeat (6) begin
			@(negedge pclk);
			cmp_b(fetch_ack, 1'b0);
		end
		@(posedge pclk);
		prog_busy <= 1'b0;
		fetch_req <= 1'b0;
		fetch(16'h0011, 1'b0);
		cmp_w({24'h0, fetch_data}, byte_of(16'h0011));
	endtask
	task t_ee;
		int n;
		for (int i = 0; i < 16; i++) apb(1'b1, 12'h01c, 32'h30 + i);
		apb(1'b1, 12'h018, 32'h0000_007f);
		apb(1'b0, 12'h010, 32'h0);
		cmp_b(rd[ST_EE_BUSY], 1'b1);
		// a second command while busy is refused and leaves the row alone
		apb(1'b1, 12'h018, 32'h0000_0005);
		apb(1'b0, 12'h010, 32'h0);
		cmp_b(rd[ST_EE_REFUSED], 1'b1);
		apb(1'b0, 12'h018, 32'h0);
		cmp_w(rd, 32'h0000_007f);
		apb(1'b1, 12'h010, 32'h0000_0020);
		apb(1'b0, 12'h010, 32'h0);
		cmp_b(rd[ST_EE_REFUSED], 1'b0);
		fetch(16'h0200, 1'b0);
		cmp_w({24'h0, fetch_data}, byte_of(16'h0200));
		n = 0;
		do begin
			apb(1'b0, 12'h010, 32'h0);
			n++;
		end while (rd[ST_EE_BUSY] !== 1'b0 && n < 300);
		cmp_b(rd[ST_EE_BUSY], 1'b0);
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			ee_addr <= 11'(127 * 16 + i);
			ee_rd <= 1'b1;
			@(posedge pclk);
			ee_rd <= 1'b0;
			@(negedge pclk);
			cmp_w({24'h0, ee_rdata}, 32'h30 + i);
		end
	endtask
	task t_sram;
		@(posedge pclk);
		cpu_sram <= '{1'b1, 1'b1, 13'h0010, 8'h11};
		dma_sram <= '{1'b1, 1'b1, 13'h1010, 8'h22};
		@(negedge pclk);
		cmp_b(dma_sram_gnt, 1'b1);
		@(posedge pclk);
		cpu_sram.we <= 1'b0;
		dma_sram.we <= 1'b0;
		@(posedge pclk);
		dma_sram <= '{1'b1, 1'b0, 13'h0020, 8'h00};
		@(negedge pclk);
		cmp_w({cpu_sram_rdata, dma_sram_rdata}, 32'h1122);
		cmp_b(dma_sram_gnt, 1'b0);
		@(posedge pclk);
		cpu_sram <= '0;
		dma_sram <= '0;
	endtask
	task t_prot;
		apb(1'b1, 12'h014, 32'h0000_0305);
		apb(1'b0, 12'h010, 32'h0);
		cmp_b(rd[ST_PROT_REFUSED], 1'b1);
		full_erase_start <= 1'b1;
		acc_block <= 8'h05;
		@(posedge pclk);
		full_erase_start <= 1'b0;
		full_erase_busy <= 1'b1;
		for (int l = 0; l < 4; l++) begin
			apb(1'b1, 12'h014, {22'h0, 2'(l), 8'h05});
			for (int m = 0; m < 4; m++) begin
				@(posedge pclk);
				acc_ext <= m[1];
				acc_write <= m[0];
				@(negedge pclk);
				cmp_b(acc_allow, l == 0 || (l == 1 && m != 2) || (l == 2 && m < 2) || m == 0);
			end
		end
		@(posedge pclk);
		full_erase_busy <= 1'b0;
		acc_block <= 8'h06;
		secure_engage <= 1'b1;
		@(posedge pclk);
		secure_engage <= 1'b0;
		repeat (2) @(negedge pclk);
		cmp_b(acc_allow, 1'b0);
		cmp_w(32'(boot_cfg.debug_port_select), 32'(DBG_DISABLED));
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs;
		t_fetch;
		t_ee;
		t_sram;
		t_prot;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		stop_test;
	end
endmodule
